/* rtl/csf_pkg.sv */
// Shared types and constants for the shift, flag and transfer execution unit.
package csf_pkg;

    // Operations that the unit carries out, one per decoded instruction form.
    typedef enum logic [4:0] {
        OP_NOP = 5'h00,
        OP_LOAD_IMM = 5'h01,
        OP_ROT_L = 5'h02,
        OP_ROT_R = 5'h03,
        OP_SHR_L = 5'h04,
        OP_SHR_A = 5'h05,
        OP_SWAP = 5'h06,
        OP_FLAG_SET = 5'h07,
        OP_FLAG_CLR = 5'h08,
        OP_BIT_TO_FLAG = 5'h09,
        OP_FLAG_TO_BIT = 5'h0A,
        OP_RD_IND = 5'h0B,
        OP_RD_OFS = 5'h0C,
        OP_RD_ABS = 5'h0D,
        OP_WR_IND = 5'h0E,
        OP_WR_OFS = 5'h0F,
        OP_WR_ABS = 5'h10,
        OP_PM_RD = 5'h11,
        OP_PM_RD0 = 5'h12,
        OP_PM_WR = 5'h13,
        OP_PUSH = 5'h14,
        OP_POP = 5'h15,
        OP_SLEEP = 5'h16,
        OP_WD_RESTART = 5'h17
    } csf_op_t;

    typedef enum logic [4:0] {
        S_IDLE = 5'b00001,
        S_MEM = 5'b00010,
        S_PM1 = 5'b00100,
        S_PM2 = 5'b01000,
        S_PMW = 5'b10000
    } csf_state_t;

    // Pointer pair select and pointer update mode.
    localparam logic [1:0] PTR_X = 2'h0;
    localparam logic [1:0] PTR_Y = 2'h1;
    localparam logic [1:0] PTR_Z = 2'h2;
    localparam logic [1:0] MODE_PLAIN = 2'h0;
    localparam logic [1:0] MODE_POSTINC = 2'h1;
    localparam logic [1:0] MODE_PREDEC = 2'h2;

    // Bit positions inside the flag register.
    localparam logic [2:0] FL_C = 3'h0;
    localparam logic [2:0] FL_Z = 3'h1;
    localparam logic [2:0] FL_N = 3'h2;
    localparam logic [2:0] FL_V = 3'h3;
    localparam logic [2:0] FL_S = 3'h4;
    localparam logic [2:0] FL_H = 3'h5;
    localparam logic [2:0] FL_T = 3'h6;
    localparam logic [2:0] FL_I = 3'h7;

    localparam logic [4:0] PTR_BASE = 5'h1A;
    localparam logic [4:0] R0_IX = 5'h00;
    localparam logic [4:0] R1_IX = 5'h01;
    localparam logic [15:0] SP_RESET = 16'h00FF;
    localparam logic [7:0] FLAGS_RESET = 8'h00;

    typedef struct packed {
        csf_op_t op;
        logic [4:0] rd;
        logic [2:0] bsel;
        logic [1:0] ptr;
        logic [1:0] mode;
        logic [5:0] ofs;
        logic [7:0] kimm;
        logic [15:0] addr;
    } csf_cmd_t;

    typedef struct packed {
        logic [15:0] addr;
        logic [7:0] wdata;
        logic we;
        logic re;
    } csf_dreq_t;

endpackage

/* rtl/csf_exec.sv */
// Execution unit for rotate, shift, flag, bit transfer, memory transfer and control operations.
`timescale 1ns/10ps
`default_nettype none

module csf_exec (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    // Command port.
    input wire logic cmd_valid,
    input wire csf_pkg::csf_cmd_t cmd,
    output logic ready,
    // Data memory and stack.
    output csf_pkg::csf_dreq_t dm_req,
    input wire logic [7:0] dm_rdata,
    // Program memory.
    output logic [14:0] pm_addr,
    output logic pm_rd,
    input wire logic [15:0] pm_rdata,
    output logic pm_wr_req,
    output logic [15:0] pm_wdata,
    input wire logic pm_wr_done,
    // Control requests.
    output logic sleep_req,
    output logic wdr_req,
    // Visibility.
    output logic [7:0] flags,
    input wire logic [4:0] reg_sel,
    output logic [7:0] reg_val
);
    import csf_pkg::*;

    typedef struct packed {
        csf_state_t state;
        logic [31:0][7:0] regs;
        logic [7:0] flags;
        logic [15:0] sp;
        csf_dreq_t dm;
        logic [4:0] dst;
        logic [14:0] pm_addr;
        logic pm_hi;
        logic pm_rd;
        logic [15:0] pm_wdata;
        logic pm_wr;
        logic sleep_p;
        logic wdr_p;
    } csf_st_t;

    csf_st_t st;
    csf_st_t next_st;

    ////////////////////////////////////////////////////////////////////////////////
    // Helpers for the datapath; ptr_get is also used by the checks.

    function automatic logic [15:0] ptr_get(input logic [31:0][7:0] r, input logic [4:0] lo);
        ptr_get = {r[lo | 5'h01], r[lo]};
    endfunction

    // Returns the carry out above the 8-bit result.
    function automatic logic [8:0] shift_op(input csf_op_t op, input logic [7:0] v, input logic c);
        case (op)
            OP_ROT_L: shift_op = {v[7], v[6:0], c};
            OP_ROT_R: shift_op = {v[0], c, v[7:1]};
            OP_SHR_L: shift_op = {v[0], 1'b0, v[7:1]};
            default: shift_op = {v[0], v[7], v[7:1]};
        endcase
    endfunction

    logic accept;
    logic [7:0] src;
    logic src_bit;
    logic h_c;
    logic [4:0] lo_ix;
    logic [15:0] ptr_val;
    logic [15:0] ofs16;
    logic [8:0] sh;
    logic [4:0] z_lo;
    logic [15:0] z_val;

    assign ready = (st.state == S_IDLE);
    assign accept = ce && cmd_valid && ready;
    assign src = st.regs[cmd.rd];
    assign src_bit = src[cmd.bsel];
    assign h_c = st.flags[FL_C];
    assign lo_ix = PTR_BASE + {2'h0, cmd.ptr, 1'b0};
    assign ptr_val = ptr_get(st.regs, lo_ix);
    assign ofs16 = {10'h000, cmd.ofs};
    assign sh = shift_op(cmd.op, src, h_c);
    assign z_lo = PTR_BASE + {2'h0, PTR_Z, 1'b0};
    assign z_val = ptr_get(st.regs, z_lo);

    ////////////////////////////////////////////////////////////////////////////////
    // Next-state logic.

    always_comb
    begin
        next_st = st;
        next_st.dm.we = 1'b0;
        next_st.dm.re = 1'b0;
        next_st.pm_rd = 1'b0;
        next_st.pm_wr = 1'b0;
        next_st.sleep_p = 1'b0;
        next_st.wdr_p = 1'b0;
        case (st.state)
            S_IDLE:
            begin
                if (accept)
                begin
                    case (cmd.op)
                        OP_LOAD_IMM:
                            next_st.regs[cmd.rd] = cmd.kimm;
                        OP_ROT_L, OP_ROT_R, OP_SHR_L, OP_SHR_A:
                        begin
                            next_st.regs[cmd.rd] = sh[7:0];
                            next_st.flags[FL_C] = sh[8];
                            next_st.flags[FL_N] = sh[7];
                            next_st.flags[FL_V] = sh[7] ^ sh[8];
                            next_st.flags[FL_Z] = (sh[7:0] == 8'h00);
                        end
                        OP_SWAP:
                            next_st.regs[cmd.rd] = {src[3:0], src[7:4]};
                        OP_FLAG_SET:
                            next_st.flags[cmd.bsel] = 1'b1;
                        OP_FLAG_CLR:
                            next_st.flags[cmd.bsel] = 1'b0;
                        OP_BIT_TO_FLAG:
                            next_st.flags[FL_T] = src_bit;
                        OP_FLAG_TO_BIT:
                            next_st.regs[cmd.rd][cmd.bsel] = st.flags[FL_T];
                        OP_RD_IND, OP_WR_IND:
                        begin
                            next_st.state = S_MEM;
                            next_st.dst = cmd.rd;
                            next_st.dm.re = (cmd.op == OP_RD_IND);
                            next_st.dm.we = (cmd.op == OP_WR_IND);
                            next_st.dm.wdata = src;
                            if (cmd.mode == MODE_PREDEC)
                            begin
                                next_st.dm.addr = ptr_val - 16'h0001;
                                {next_st.regs[lo_ix | 5'h01], next_st.regs[lo_ix]} = ptr_val - 16'h0001;
                            end
                            else
                            begin
                                next_st.dm.addr = ptr_val;
                                if (cmd.mode == MODE_POSTINC)
                                begin
                                    {next_st.regs[lo_ix | 5'h01], next_st.regs[lo_ix]} = ptr_val + 16'h0001;
                                end
                            end
                        end
                        OP_RD_OFS, OP_WR_OFS:
                        begin
                            next_st.state = S_MEM;
                            next_st.dst = cmd.rd;
                            next_st.dm.re = (cmd.op == OP_RD_OFS);
                            next_st.dm.we = (cmd.op == OP_WR_OFS);
                            next_st.dm.wdata = src;
                            next_st.dm.addr = ptr_val + ofs16;
                        end
                        OP_RD_ABS, OP_WR_ABS:
                        begin
                            next_st.state = S_MEM;
                            next_st.dst = cmd.rd;
                            next_st.dm.re = (cmd.op == OP_RD_ABS);
                            next_st.dm.we = (cmd.op == OP_WR_ABS);
                            next_st.dm.wdata = src;
                            next_st.dm.addr = cmd.addr;
                        end
                        OP_PUSH:
                        begin
                            next_st.state = S_MEM;
                            next_st.dm.we = 1'b1;
                            next_st.dm.wdata = src;
                            next_st.dm.addr = st.sp;
                            next_st.sp = st.sp - 16'h0001;
                        end
                        OP_POP:
                        begin
                            next_st.state = S_MEM;
                            next_st.dst = cmd.rd;
                            next_st.dm.re = 1'b1;
                            next_st.dm.addr = st.sp + 16'h0001;
                            next_st.sp = st.sp + 16'h0001;
                        end
                        OP_PM_RD, OP_PM_RD0:
                        begin
                            // The pointer always comes from Z, whatever the select says.
                            next_st.state = S_PM1;
                            next_st.dst = (cmd.op == OP_PM_RD0) ? R0_IX : cmd.rd;
                            next_st.pm_addr = z_val[15:1];
                            next_st.pm_hi = z_val[0];
                            next_st.pm_rd = 1'b1;
                            if (cmd.op == OP_PM_RD && cmd.mode == MODE_POSTINC)
                            begin
                                {next_st.regs[z_lo | 5'h01], next_st.regs[z_lo]} = z_val + 16'h0001;
                            end
                        end
                        OP_PM_WR:
                        begin
                            next_st.state = S_PMW;
                            next_st.pm_addr = z_val[15:1];
                            next_st.pm_wdata = {st.regs[R1_IX], st.regs[R0_IX]};
                            next_st.pm_wr = 1'b1;
                        end
                        OP_SLEEP:
                            next_st.sleep_p = 1'b1;
                        OP_WD_RESTART:
                            next_st.wdr_p = 1'b1;
                        default:
                            next_st.state = S_IDLE;
                    endcase
                end
            end
            S_MEM:
            begin
                if (st.dm.re)
                begin
                    next_st.regs[st.dst] = dm_rdata;
                end
                next_st.state = S_IDLE;
            end
            S_PM1:
                next_st.state = S_PM2;
            S_PM2:
            begin
                next_st.regs[st.dst] = st.pm_hi ? pm_rdata[15:8] : pm_rdata[7:0];
                next_st.state = S_IDLE;
            end
            S_PMW:
            begin
                if (pm_wr_done)
                begin
                    next_st.state = S_IDLE;
                end
            end
            default:
                next_st.state = S_IDLE;
        endcase
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            st <= '0;
            st.state <= S_IDLE;
            st.sp <= SP_RESET;
            st.flags <= FLAGS_RESET;
        end
        else if (ce)
        begin
            st <= next_st;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Outputs.

    assign dm_req = st.dm;
    assign pm_addr = st.pm_addr;
    assign pm_rd = st.pm_rd;
    assign pm_wr_req = st.pm_wr;
    assign pm_wdata = st.pm_wdata;
    assign sleep_req = st.sleep_p;
    assign wdr_req = st.wdr_p;
    assign flags = st.flags;
    assign reg_val = st.regs[reg_sel];

    ////////////////////////////////////////////////////////////////////////////////
    // Checks.

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    a_rot_left: assert property (
        accept && cmd.op == OP_ROT_L |=>
        st.regs[$past(cmd.rd)] == {$past(src[6:0]), $past(h_c)} && st.flags[FL_C] == $past(src[7]))
        else $error("rotate left result or carry wrong");

    a_rot_right: assert property (
        accept && cmd.op == OP_ROT_R |=>
        st.regs[$past(cmd.rd)] == {$past(h_c), $past(src[7:1])} && st.flags[FL_C] == $past(src[0])
        && st.flags[FL_Z] == (st.regs[$past(cmd.rd)] == 8'h00))
        else $error("rotate right result or flags wrong");

    a_bit_flag: assert property (
        accept && cmd.op == OP_BIT_TO_FLAG |=>
        st.flags[FL_T] == $past(src_bit) && ((st.flags ^ $past(st.flags)) & 8'hBF) == 8'h00)
        else $error("bit to transfer flag wrong");

    a_flag_bit: assert property (
        accept && cmd.op == OP_FLAG_TO_BIT |=>
        st.flags == $past(st.flags) && st.regs[$past(cmd.rd)][$past(cmd.bsel)] == $past(st.flags[FL_T]))
        else $error("transfer flag to bit wrong");

    a_flag_only: assert property (
        accept && cmd.op == OP_FLAG_SET |=> st.flags == ($past(st.flags) | (8'h01 << $past(cmd.bsel))))
        else $error("flag set touched other flags");

    a_flag_clear: assert property (
        accept && cmd.op == OP_FLAG_CLR |=> st.flags == ($past(st.flags) & ~(8'h01 << $past(cmd.bsel))))
        else $error("flag clear touched other flags");

    a_rd_post: assert property (
        accept && cmd.op == OP_RD_IND && cmd.mode == MODE_POSTINC |=>
        dm_req.re && dm_req.addr == $past(ptr_val) && !ready ##1 ready)
        else $error("post increment read wrong");

    a_wr_pre: assert property (
        accept && cmd.op == OP_WR_IND && cmd.mode == MODE_PREDEC |=>
        dm_req.we && dm_req.addr == $past(ptr_val) - 16'h0001 && dm_req.wdata == $past(src))
        else $error("pre decrement write wrong");

    a_rd_ofs: assert property (
        accept && cmd.op == OP_RD_OFS |=>
        dm_req.re && dm_req.addr == $past(ptr_val) + $past(ofs16)
        && ptr_get(st.regs, $past(lo_ix)) == $past(ptr_val))
        else $error("offset read wrong");

    a_pm_three: assert property (
        accept && (cmd.op == OP_PM_RD || cmd.op == OP_PM_RD0) |=>
        pm_rd && !ready ##1 !pm_rd && !ready ##1 ready)
        else $error("program read not three cycles");

    a_push_wr: assert property (
        accept && cmd.op == OP_PUSH |=>
        dm_req.we && dm_req.addr == $past(st.sp) && st.flags == $past(st.flags))
        else $error("push wrong");

    a_sleep_req: assert property (
        accept && cmd.op == OP_SLEEP |=> sleep_req && ready && st.flags == $past(st.flags) ##1 !sleep_req)
        else $error("sleep request wrong");

    a_wd_pulse: assert property (
        accept && cmd.op == OP_WD_RESTART |=> wdr_req && st.flags == $past(st.flags))
        else $error("watchdog restart wrong");

    c_pm_read: cover property (accept && cmd.op == OP_PM_RD ##3 ready);
    c_push_pop: cover property (accept && cmd.op == OP_PUSH ##2 accept && cmd.op == OP_POP);
    c_rot_chain: cover property (accept && cmd.op == OP_ROT_L ##1 accept && cmd.op == OP_ROT_R);
    c_pm_write: cover property (accept && cmd.op == OP_PM_WR ##[1:20] ready);

endmodule

`default_nettype wire

/* tb/csf_mem_model.sv */
// Data memory, stack and program memory on the far side of the execution unit.
`timescale 1ns/10ps
`default_nettype none

module csf_mem_model #(
    parameter int WR_WAIT = 3
)
(
    // Clock.
    input wire logic clk,
    // Data memory and stack.
    input wire csf_pkg::csf_dreq_t dm_req,
    output logic [7:0] dm_rdata,
    // Program memory.
    input wire logic [14:0] pm_addr,
    input wire logic pm_rd,
    output logic [15:0] pm_rdata,
    input wire logic pm_wr_req,
    input wire logic [15:0] pm_wdata,
    output logic pm_wr_done
);
    import csf_pkg::*;
    logic [7:0] mem [0:65535];
    logic [15:0] pm [0:32767];
    logic [7:0] last_rd = 8'h00;
    logic [15:0] last_pm = 16'h0000;
    logic [14:0] pm_a = 15'h0000;
    logic pm_ok = 1'b0;
    int wr_cnt = 0;

    initial pm_wr_done = 1'b0;

    // Outside a strobed read the data lines flip, so stale data is never mistaken for valid.
    always_comb
    begin
        dm_rdata = dm_req.re ? mem[dm_req.addr] : ~last_rd;
        pm_rdata = pm_ok ? pm[pm_a] : ~last_pm;
    end

    always @(posedge clk)
    begin
        if (dm_req.re)
            last_rd <= mem[dm_req.addr];
        if (dm_req.we)
            mem[dm_req.addr] <= dm_req.wdata;
        pm_ok <= pm_rd;
        if (pm_rd)
            pm_a <= pm_addr;
        if (pm_ok)
            last_pm <= pm[pm_a];
        pm_wr_done <= (wr_cnt == 1);
        if (pm_wr_req)
        begin
            pm[pm_addr] <= pm_wdata;
            wr_cnt <= WR_WAIT;
        end
        else if (wr_cnt != 0)
            wr_cnt <= wr_cnt - 1;
    end
endmodule
`default_nettype wire

/* tb/test_csf_exec.sv */
// Self-checking bench for the shift, flag and transfer execution unit.
`timescale 1ns/10ps
`default_nettype none

module test_csf_exec;
    import csf_pkg::*;
    logic clk, rst, ce, cmd_valid, ready, pm_rd, pm_wr_req, pm_wr_done, sleep_req, wdr_req;
    csf_cmd_t cmd;
    csf_dreq_t dm_req;
    logic [7:0] dm_rdata, flags, reg_val;
    logic [14:0] pm_addr;
    logic [15:0] pm_rdata, pm_wdata, cyc;
    logic [4:0] reg_sel;
    int n_errors = 0;
    int checks_done = 0;
    int ticks = 0;

    csf_exec dut_u (.clk(clk), .rst(rst), .ce(ce), .cmd_valid(cmd_valid), .cmd(cmd), .ready(ready),
        .dm_req(dm_req), .dm_rdata(dm_rdata), .pm_addr(pm_addr), .pm_rd(pm_rd), .pm_rdata(pm_rdata),
        .pm_wr_req(pm_wr_req), .pm_wdata(pm_wdata), .pm_wr_done(pm_wr_done), .sleep_req(sleep_req),
        .wdr_req(wdr_req), .flags(flags), .reg_sel(reg_sel), .reg_val(reg_val));
    csf_mem_model mem_u (.clk(clk), .dm_req(dm_req), .dm_rdata(dm_rdata), .pm_addr(pm_addr),
        .pm_rd(pm_rd), .pm_rdata(pm_rdata), .pm_wr_req(pm_wr_req), .pm_wdata(pm_wdata),
        .pm_wr_done(pm_wr_done));

    always #20 clk = ~clk;

    always @(posedge clk)
    begin
        ticks++;
        if (ticks == 3000)
        begin
            n_errors++;
            $display("MISMATCH at %0t: run did not finish", $time);
            results();
        end
    end

    task automatic results();
        if (n_errors == 0 && checks_done > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            n_errors++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Offers one command and returns once ready is back; cyc counts edges from acceptance.
    task automatic mop(input csf_op_t o, input logic [4:0] r, input logic [1:0] p, input logic [1:0] m,
        input logic [15:0] a, input logic [2:0] b = 3'h0);
        @(negedge clk);
        cmd = '{op: o, rd: r, bsel: b, ptr: p, mode: m, ofs: a[5:0], kimm: a[7:0], addr: a};
        cmd_valid = 1'b1;
        @(posedge clk);
        cyc = 16'h0001;
        @(negedge clk);
        cmd_valid = 1'b0;
        while (ready !== 1'b1 && cyc < 16'h0028)
        begin
            @(posedge clk);
            cyc++;
            @(negedge clk);
        end
    endtask

    task automatic op(input csf_op_t o, input logic [4:0] r, input logic [2:0] b);
        mop(o, r, PTR_X, MODE_PLAIN, 16'h0000, b);
    endtask

    task automatic ld(input logic [4:0] r, input logic [7:0] v);
        mop(OP_LOAD_IMM, r, PTR_X, MODE_PLAIN, {8'h00, v});
    endtask

    task automatic creg(input logic [4:0] r, input logic [7:0] e);
        reg_sel = r;
        #1;
        chk(reg_val, e);
    endtask

    task automatic pset(input logic [4:0] r, input logic [15:0] v);
        ld(r, v[7:0]);
        ld(r + 5'h01, v[15:8]);
    endtask

    task automatic pchk(input logic [4:0] r, input logic [15:0] v);
        creg(r, v[7:0]);
        creg(r + 5'h01, v[15:8]);
    endtask

    ////////////////////////////////////////////////////////////
    task automatic t_rotate();
        ld(5'h10, 8'h81);
        op(OP_FLAG_SET, 5'h00, FL_C);
        op(OP_ROT_L, 5'h10, 3'h0);
        chk(cyc, 16'h0001);
        creg(5'h10, 8'h03);
        chk(flags, 8'h09);
        op(OP_ROT_R, 5'h10, 3'h0);
        chk(cyc, 16'h0001);
        creg(5'h10, 8'h81);
        chk(flags, 8'h05);
        op(OP_FLAG_CLR, 5'h00, FL_C);
        ld(5'h10, 8'h80);
        op(OP_ROT_L, 5'h10, 3'h0);
        creg(5'h10, 8'h00);
        chk(flags, 8'h0B);
    endtask

    task automatic t_shift();
        ld(5'h10, 8'h81);
        op(OP_SHR_L, 5'h10, 3'h0);
        creg(5'h10, 8'h40);
        chk(flags, 8'h09);
        ld(5'h10, 8'h81);
        op(OP_SHR_A, 5'h10, 3'h0);
        creg(5'h10, 8'hC0);
        chk(flags, 8'h05);
        ld(5'h10, 8'hA5);
        op(OP_SWAP, 5'h10, 3'h0);
        creg(5'h10, 8'h5A);
        chk({cyc[7:0], flags}, 16'h0105);
    endtask

    task automatic t_flags();
        logic [7:0] e;
        e = 8'h05;
        for (int p = 0; p < 2; p++)
            for (int i = 0; i < 8; i++)
            begin
                op((p == 1) ? OP_FLAG_SET : OP_FLAG_CLR, 5'h00, 3'(i));
                e[i] = (p == 1);
                chk({cyc[7:0], flags}, {8'h01, e});
            end
    endtask

    task automatic t_bit();
        ld(5'h05, 8'h10);
        op(OP_BIT_TO_FLAG, 5'h05, 3'h3);
        chk(flags, 8'hBF);
        op(OP_BIT_TO_FLAG, 5'h05, 3'h4);
        chk({cyc[7:0], flags}, 16'h01FF);
        ld(5'h07, 8'hF0);
        op(OP_FLAG_TO_BIT, 5'h07, 3'h2);
        creg(5'h07, 8'hF4);
        chk({cyc[7:0], flags}, 16'h01FF);
        op(OP_FLAG_CLR, 5'h00, FL_T);
        op(OP_FLAG_TO_BIT, 5'h07, 3'h2);
        creg(5'h07, 8'hF0);
    endtask

    task automatic t_mem();
        mem_u.mem[16'h00FF] = 8'h3C;
        mem_u.mem[16'h0100] = 8'hC3;
        pset(5'h1A, 16'h00FF);
        mop(OP_RD_IND, 5'h02, PTR_X, MODE_POSTINC, 16'h0000);
        chk(cyc, 16'h0002);
        creg(5'h02, 8'h3C);
        pchk(5'h1A, 16'h0100);
        mop(OP_RD_IND, 5'h03, PTR_X, MODE_PREDEC, 16'h0000);
        chk(cyc, 16'h0002);
        creg(5'h03, 8'h3C);
        pchk(5'h1A, 16'h00FF);
        ld(5'h04, 8'h77);
        mop(OP_WR_IND, 5'h04, PTR_X, MODE_POSTINC, 16'h0000);
        chk(mem_u.mem[16'h00FF], 8'h77);
        pchk(5'h1A, 16'h0100);
        mop(OP_WR_IND, 5'h02, PTR_X, MODE_PREDEC, 16'h0000);
        chk(cyc, 16'h0002);
        chk(mem_u.mem[16'h00FF], 8'h3C);
        mem_u.mem[16'h023F] = 8'h5A;
        pset(5'h1C, 16'h0200);
        mop(OP_RD_OFS, 5'h08, PTR_Y, MODE_PLAIN, 16'h003F);
        creg(5'h08, 8'h5A);
        pchk(5'h1C, 16'h0200);
        pset(5'h1E, 16'h03FF);
        mop(OP_WR_OFS, 5'h08, PTR_Z, MODE_PLAIN, 16'h0001);
        chk(mem_u.mem[16'h0400], 8'h5A);
        pchk(5'h1E, 16'h03FF);
        mem_u.mem[16'h1234] = 8'hE7;
        mop(OP_RD_ABS, 5'h09, PTR_X, MODE_PLAIN, 16'h1234);
        chk(cyc, 16'h0002);
        creg(5'h09, 8'hE7);
        mop(OP_WR_ABS, 5'h09, PTR_X, MODE_PLAIN, 16'h4321);
        chk(mem_u.mem[16'h4321], 8'hE7);
        chk({cyc[7:0], flags}, 16'h02BF);
    endtask

    task automatic t_pm();
        mem_u.pm[15'h0002] = 16'hBEEF;
        mem_u.pm[15'h0003] = 16'h1234;
        pset(5'h1E, 16'h0005);
        mop(OP_PM_RD, 5'h09, PTR_Z, MODE_POSTINC, 16'h0000);
        chk(cyc, 16'h0003);
        creg(5'h09, 8'hBE);
        pchk(5'h1E, 16'h0006);
        mop(OP_PM_RD0, 5'h09, PTR_Z, MODE_PLAIN, 16'h0000);
        creg(5'h00, 8'h34);
        pchk(5'h1E, 16'h0006);
        ld(5'h01, 8'hAB);
        mop(OP_PM_WR, 5'h00, PTR_Z, MODE_PLAIN, 16'h0000);
        chk(mem_u.pm[15'h0003], 16'hAB34);
        chk({15'h0000, cyc > 16'h0003}, 16'h0001);
    endtask

    task automatic t_stack();
        ld(5'h10, 8'h11);
        ld(5'h11, 8'h22);
        op(OP_PUSH, 5'h10, 3'h0);
        chk(cyc, 16'h0002);
        chk(mem_u.mem[16'h00FF], 8'h11);
        op(OP_PUSH, 5'h11, 3'h0);
        chk(mem_u.mem[16'h00FE], 8'h22);
        op(OP_POP, 5'h14, 3'h0);
        creg(5'h14, 8'h22);
        op(OP_POP, 5'h15, 3'h0);
        creg(5'h15, 8'h11);
        chk({cyc[7:0], flags}, 16'h02BF);
    endtask

    task automatic t_ctrl();
        op(OP_SLEEP, 5'h00, 3'h0);
        chk({sleep_req, wdr_req}, 2'b10);
        op(OP_WD_RESTART, 5'h00, 3'h0);
        chk({sleep_req, wdr_req}, 2'b01);
        @(negedge clk);
        chk({sleep_req, wdr_req, flags}, 10'h0BF);
        ce = 1'b0;
        cmd.op = OP_FLAG_SET;
        cmd.bsel = FL_T;
        cmd_valid = 1'b1;
        repeat (3) @(negedge clk);
        chk(flags, 8'hBF);
        cmd_valid = 1'b0;
        ce = 1'b1;
    endtask

    initial
    begin
        clk = 1'b0;
        rst = 1'b1;
        ce = 1'b1;
        cmd_valid = 1'b0;
        cmd = '0;
        reg_sel = 5'h00;
        cyc = 16'h0000;
        repeat (6) @(posedge clk);
        @(negedge clk);
        rst = 1'b0;
        chk({ready, flags}, 9'h100);
        t_rotate();
        t_shift();
        t_flags();
        t_bit();
        t_mem();
        t_pm();
        t_stack();
        t_ctrl();
        results();
    end
endmodule
`default_nettype wire
